//--- core/flash_seq_defs.vh
// Constants for the flash status and suspend control block.
`ifndef FLASH_SEQ_DEFS_VH
`define FLASH_SEQ_DEFS_VH
// Register byte offsets.
`define FS_OFF_CMD    8'h00
`define FS_OFF_STAT   8'h04
`define FS_OFF_MODE   8'h08
`define FS_OFF_SER    8'h0C
`define FS_OFF_IDLO   8'h10
`define FS_OFF_IDHI   8'h14
// Command port fields.
`define FS_CMD_BYTE   7:0
`define FS_CMD_BLK    15:8
// Status register bit positions.
`define FS_ST_READY   7
`define FS_ST_ESUS    6
`define FS_ST_EERR    5
`define FS_ST_PERR    4
`define FS_ST_PSUS    3
`define FS_ST_LBDATA  1
`define FS_ST_IDOK    0
// Mode register bit positions.
`define FS_MD_SUSEN   0
`define FS_MD_SUSREQ  1
`define FS_MD_IRQSUS  2
`define FS_MD_MODEB   3
// Serial pin register bit positions.
`define FS_SR_TX      0
`define FS_SR_M3      1
`define FS_SR_DRV     2
`define FS_SR_RX      4
`define FS_SR_STRAP   5
// Command codes.
`define FS_C_CLRST    8'h50
`define FS_C_RDARR    8'hFF
`define FS_C_PROG     8'h40
`define FS_C_ERASE    8'h20
`define FS_C_LOCK     8'h77
`define FS_C_RDLOCK   8'h71
`define FS_C_BLANK    8'h25
`define FS_C_CONFIRM  8'hD0
`define FS_BLANK_VAL  8'hFF
// Reset values.
`define FS_MODE_RST   4'h0
`define FS_SER_RST    3'h1
// Operation lengths and suspend latency, in pclk cycles.
`define FS_ERASE_CYC  16'd8000
`define FS_PROG_CYC   16'd200
`define FS_LOCK_CYC   16'd200
`define FS_BLANK_CYC  16'd256
`define FS_RDLK_CYC   16'd4
`define FS_SUSLAT_CYC 8'd20
`endif

//--- core/flash_seq_ctrl.v
// Flash rewrite sequencer: commands, error status, suspend/resume and serial boot pins.
`timescale 1ns/1ps
`include "flash_seq_defs.vh"

// Notes on behaviour
// - Failing command sets one or both error flags.
// - Malformed sequence or bad confirm sets both flags.
// - Erase during erase suspend is sequence error.
// - Program or erase during program suspend: sequence error.
// - Command to the suspended block: sequence error.
// - Failed erase: erase flag one, program zero.
// - Blank check seeing non-FFh byte: erase flag.
// - Failed program: program flag only.
// - Lock bit left unlocked: program flag only.
// - FFh second cycle discards any command but program, read array.
// - Mode two: mode pin low, separate TX/RX.
// - Mode three: mode pin is bidirectional data.
// - Serial access only after identification codes match.
// - Mode A: acknowledged interrupt auto-raises suspend request.
// - Suspended erase/program limits access to other blocks.
// - Clearing suspend request resumes the operation.
// - Mode A without suspend: interrupts run alongside.
// - Mode B auto suspend: suspend first, then interrupt.
// - Mode B otherwise: interrupts wait for completion.
// - Ready flag low while operation runs.
// - Clear-status command clears both error flags.
module flash_seq_ctrl #(
  parameter CNT_W     = 16,
  parameter ERASE_CYC = `FS_ERASE_CYC,
  parameter PROG_CYC  = `FS_PROG_CYC,
  parameter LOCK_CYC  = `FS_LOCK_CYC,
  parameter BLANK_CYC = `FS_BLANK_CYC,
  parameter RDLK_CYC  = `FS_RDLK_CYC,
  parameter SUS_LAT   = `FS_SUSLAT_CYC,
  parameter ID_W      = 56
) (
  input  wire            pclk,        // System clock
  input  wire            presetn,     // Asynchronous reset, active low
  input  wire            psel,        // APB select
  input  wire            penable,     // APB enable
  input  wire            pwrite,      // APB direction
  input  wire [7:0]      paddr,       // APB byte address
  input  wire [31:0]     pwdata,      // APB write data
  output reg  [31:0]     prdata,      // APB read data
  output wire            pready,      // APB ready
  output reg             pslverr,     // APB error on unmapped offset
  input  wire            op_fail,     // Flash macro verify failed
  input  wire            lock_bit_rd, // Lock bit of the current block
  input  wire [7:0]      blank_byte,  // Byte read during blank check
  input  wire            blank_valid, // Blank byte strobe
  input  wire            irq_req,     // Pending maskable interrupt
  input  wire            irq_ack,     // CPU acknowledged an interrupt
  output wire            irq_allow,   // CPU may service interrupts
  input  wire            acc_valid,   // CPU array access request
  input  wire            acc_write,   // CPU array access is a write
  input  wire [7:0]      acc_block,   // Block of the CPU access
  output wire            acc_allow,   // CPU array access permitted
  output reg             flash_run,   // Flash macro operation running
  output reg  [2:0]      flash_op,    // Flash macro operation kind
  output reg  [7:0]      flash_blk,   // Flash macro target block
  input  wire [ID_W-1:0] id_stored,   // Identification codes held in flash
  output wire            id_granted,  // Identification match latched
  input  wire            mode_i,      // Mode pin level
  output wire            mode_o,      // Mode pin drive value
  output wire            mode_oe_n,   // Mode pin drive enable, active low
  output wire            txd_o,       // Serial transmit pin
  input  wire            rxd_i        // Serial receive pin
);

  localparam [2:0] OP_NONE = 3'd0;
  localparam [2:0] OP_ERS  = 3'd1;
  localparam [2:0] OP_PRG  = 3'd2;
  localparam [2:0] OP_LCK  = 3'd3;
  localparam [2:0] OP_RLK  = 3'd4;
  localparam [2:0] OP_BLK  = 3'd5;
  // Last count of the suspend latency counter; only the low byte is compared.
  localparam integer SUS_LAT_M1 = SUS_LAT - 1;

  function [2:0] code_op;
    input [7:0] c;
    begin
      case (c)
        `FS_C_ERASE:  code_op = OP_ERS;
        `FS_C_PROG:   code_op = OP_PRG;
        `FS_C_LOCK:   code_op = OP_LCK;
        `FS_C_RDLOCK: code_op = OP_RLK;
        `FS_C_BLANK:  code_op = OP_BLK;
        default:      code_op = OP_NONE;
      endcase
    end
  endfunction

  function [CNT_W-1:0] op_len;
    input [2:0] o;
    begin
      case (o)
        OP_ERS:  op_len = ERASE_CYC[CNT_W-1:0];
        OP_PRG:  op_len = PROG_CYC[CNT_W-1:0];
        OP_LCK:  op_len = LOCK_CYC[CNT_W-1:0];
        OP_BLK:  op_len = BLANK_CYC[CNT_W-1:0];
        default: op_len = RDLK_CYC[CNT_W-1:0];
      endcase
    end
  endfunction

  // Pin synchronisers.
  reg        mode_m_q, mode_s_q, rxd_m_q, rxd_s_q;
  reg        strap_q, strap_done_q;
  reg [1:0]  strap_cnt_q;
  // Registers.
  reg [3:0]  mode_q;
  reg [2:0]  ser_q;
  reg [31:0] idlo_q;
  reg        id_ok_q;
  reg        eerr_q, perr_q, lbdata_q;
  // Command and operation state.
  reg        first_q;
  reg [2:0]  fop_q;
  reg [7:0]  fblk_q;
  reg [CNT_W-1:0] cnt_q, sus_cnt_q;
  reg [2:0]  sus_op_q;
  reg [7:0]  sus_blk_q;
  reg        sus_q, bad_q;
  reg [7:0]  lat_q;

  wire       wen    = psel & penable & pwrite;
  wire       rsetup = psel & ~penable;
  wire [7:0] cbyte  = pwdata[`FS_CMD_BYTE];
  wire [7:0] cblk   = pwdata[`FS_CMD_BLK];
  wire       sus_en = mode_q[`FS_MD_SUSEN];
  wire       sreq   = mode_q[`FS_MD_SUSREQ];
  wire       irqsus = mode_q[`FS_MD_IRQSUS];
  wire       mode_b = mode_q[`FS_MD_MODEB];
  wire       serial = strap_done_q & ~strap_q;

  assign pready = 1'b1;

  // In serial boot the command port stays shut until the programmer's codes match.
  wire cmd_ok  = ~serial | id_ok_q;
  wire cmd_wr  = wen & (paddr == `FS_OFF_CMD) & ~flash_run & cmd_ok;
  wire susable = flash_run & ~sus_q & sus_en & ((flash_op == OP_ERS) | (flash_op == OP_PRG));

  // Mode A reacts to the acknowledge, mode B to the raw request.
  wire auto_sus = susable & irqsus & (mode_b ? irq_req : irq_ack);

  // Suspend conflicts checked on the confirming cycle.
  wire conflict = sus_q & (((sus_op_q == OP_ERS) & (fop_q == OP_ERS)) |
                           (sus_op_q == OP_PRG) |
                           (fop_q == OP_BLK) |
                           (fblk_q == sus_blk_q));

  reg        seq_err, clr_st, start;
  always @* begin
    seq_err = 1'b0;
    clr_st  = 1'b0;
    start   = 1'b0;
    if (cmd_wr) begin
      if (!first_q) begin
        if (cbyte == `FS_C_CLRST)
          clr_st = 1'b1;
        else if (cbyte != `FS_C_RDARR && code_op(cbyte) == OP_NONE)
          seq_err = 1'b1;
      end else if (fop_q != OP_PRG && cbyte == `FS_C_RDARR) begin
        seq_err = 1'b0;
      end else if (fop_q != OP_PRG && cbyte != `FS_C_CONFIRM) begin
        seq_err = 1'b1;
      end else if (conflict) begin
        seq_err = 1'b1;
      end else begin
        start = 1'b1;
      end
    end
  end

  wire done     = flash_run & (cnt_q == {CNT_W{1'b0}});
  wire lat_hit  = susable & sreq & (lat_q == SUS_LAT_M1[7:0]);
  wire do_sus   = lat_hit & ~done;
  wire resume   = sus_q & ~sreq & ~flash_run & ~first_q;
  wire blank_ng = blank_valid & (blank_byte != `FS_BLANK_VAL);

  // Error flags: hardware set wins over the clear command.
  wire set_e = seq_err |
               (done & (flash_op == OP_ERS) & op_fail) |
               (done & (flash_op == OP_BLK) & (bad_q | blank_ng));
  wire set_p = seq_err |
               (done & (flash_op == OP_PRG) & op_fail) |
               (done & (flash_op == OP_LCK) & lock_bit_rd);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eerr_q   <= 1'b0;
      perr_q   <= 1'b0;
      lbdata_q <= 1'b0;
    end else begin
      eerr_q <= (eerr_q & ~clr_st) | set_e;
      perr_q <= (perr_q & ~clr_st) | set_p;
      if (done && flash_op == OP_RLK)
        lbdata_q <= lock_bit_rd;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 1'b0;
      fop_q   <= OP_NONE;
      fblk_q  <= 8'h00;
    end else if (cmd_wr) begin
      if (!first_q && code_op(cbyte) != OP_NONE) begin
        first_q <= 1'b1;
        fop_q   <= code_op(cbyte);
        fblk_q  <= cblk;
      end else begin
        first_q <= 1'b0;
      end
    end
  end

  // Operation engine with a single suspend slot.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_run <= 1'b0;
      flash_op  <= OP_NONE;
      flash_blk <= 8'h00;
      cnt_q     <= {CNT_W{1'b0}};
      bad_q     <= 1'b0;
      sus_q     <= 1'b0;
      sus_op_q  <= OP_NONE;
      sus_blk_q <= 8'h00;
      sus_cnt_q <= {CNT_W{1'b0}};
      lat_q     <= 8'h00;
    end else begin
      if (susable && sreq && !lat_hit)
        lat_q <= lat_q + 8'd1;
      else
        lat_q <= 8'h00;
      if (start) begin
        flash_run <= 1'b1;
        flash_op  <= fop_q;
        flash_blk <= fblk_q;
        cnt_q     <= op_len(fop_q);
        bad_q     <= 1'b0;
      end else if (resume) begin
        flash_run <= 1'b1;
        flash_op  <= sus_op_q;
        flash_blk <= sus_blk_q;
        cnt_q     <= sus_cnt_q;
        sus_q     <= 1'b0;
      end else if (done) begin
        flash_run <= 1'b0;
        flash_op  <= OP_NONE;
      end else if (do_sus) begin
        flash_run <= 1'b0;
        sus_q     <= 1'b1;
        sus_op_q  <= flash_op;
        sus_blk_q <= flash_blk;
        sus_cnt_q <= cnt_q;
        flash_op  <= OP_NONE;
      end else if (flash_run) begin
        cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        if (flash_op == OP_BLK && blank_ng)
          bad_q <= 1'b1;
      end
    end
  end

  // Interrupt arbitration; a running operation in mode B holds interrupts back.
  assign irq_allow = ~mode_b | ~flash_run;

  // Array access while an operation is suspended.
  assign acc_allow = acc_valid & ~flash_run &
                     (~sus_q | ((acc_block != sus_blk_q) &
                                ((sus_op_q == OP_ERS) | ~acc_write)));

  // Mode register; the interrupt-raised request wins over a software clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `FS_MODE_RST;
    end else if (wen && paddr == `FS_OFF_MODE) begin
      mode_q <= pwdata[3:0] | {2'b00, auto_sus, 1'b0};
    end else if (auto_sus) begin
      mode_q[`FS_MD_SUSREQ] <= 1'b1;
    end
  end

  // Boot pins; the strap is caught on the third edge after reset release.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_m_q     <= 1'b1;
      mode_s_q     <= 1'b1;
      rxd_m_q      <= 1'b1;
      rxd_s_q      <= 1'b1;
      strap_q      <= 1'b1;
      strap_done_q <= 1'b0;
      strap_cnt_q  <= 2'd0;
    end else begin
      mode_m_q <= mode_i;
      mode_s_q <= mode_m_q;
      rxd_m_q  <= rxd_i;
      rxd_s_q  <= rxd_m_q;
      // The synchronisers reset high, so the pin level is only valid after two edges.
      if (!strap_done_q) begin
        if (strap_cnt_q == 2'd2) begin
          strap_q      <= mode_s_q;
          strap_done_q <= 1'b1;
        end else begin
          strap_cnt_q <= strap_cnt_q + 2'd1;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ser_q <= `FS_SER_RST;
    else if (wen && paddr == `FS_OFF_SER)
      ser_q <= pwdata[2:0];
  end

  wire m3 = ser_q[`FS_SR_M3];
  // Mode two keeps the mode pin an input and uses the separate TX and RX pins.
  assign txd_o     = ~serial | m3 | ser_q[`FS_SR_TX];
  // Mode three turns the mode pin into the one data line.
  assign mode_o    = ser_q[`FS_SR_TX];
  assign mode_oe_n = ~(serial & m3 & ser_q[`FS_SR_DRV]);
  wire   rx_bit    = m3 ? mode_s_q : rxd_s_q;

  // Identification codes; the compare is taken when the high word lands.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idlo_q  <= 32'h0000_0000;
      id_ok_q <= 1'b0;
    end else if (wen && paddr == `FS_OFF_IDLO) begin
      idlo_q <= pwdata;
    end else if (wen && paddr == `FS_OFF_IDHI) begin
      id_ok_q <= ({pwdata[ID_W-33:0], idlo_q} == id_stored);
    end
  end
  assign id_granted = id_ok_q;

  // Read data is captured in the setup cycle so that prdata comes from a flop.
  reg [31:0] rd_d;
  reg        err_d;
  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      `FS_OFF_CMD:  rd_d = 32'h0000_0000;
      `FS_OFF_STAT: begin
        rd_d[`FS_ST_READY]  = ~flash_run;
        rd_d[`FS_ST_ESUS]   = sus_q & (sus_op_q == OP_ERS);
        rd_d[`FS_ST_EERR]   = eerr_q;
        rd_d[`FS_ST_PERR]   = perr_q;
        rd_d[`FS_ST_PSUS]   = sus_q & (sus_op_q == OP_PRG);
        rd_d[`FS_ST_LBDATA] = lbdata_q;
        rd_d[`FS_ST_IDOK]   = id_ok_q;
      end
      `FS_OFF_MODE: rd_d[3:0] = mode_q;
      `FS_OFF_SER: begin
        rd_d[2:0]          = ser_q;
        rd_d[`FS_SR_RX]    = rx_bit;
        rd_d[`FS_SR_STRAP] = strap_q;
      end
      `FS_OFF_IDLO: rd_d = 32'h0000_0000;
      `FS_OFF_IDHI: rd_d = 32'h0000_0000;
      default:      err_d = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rsetup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr <= err_d;
    end
  end

endmodule

//--- tb/flash_seq_props.sv
// Port-level checker for the flash sequencer.
`timescale 1ns/1ps
module flash_seq_props (
  input logic        pclk,       // Clock
  input logic        presetn,    // Reset, active low
  input logic        psel,       // APB select
  input logic        penable,    // APB enable
  input logic        pwrite,     // APB direction
  input logic [7:0]  paddr,      // APB address
  input logic [31:0] prdata,     // APB read data
  input logic        pready,     // APB ready
  input logic        pslverr,    // APB error
  input logic        irq_allow,  // Interrupt service allowed
  input logic        acc_valid,  // Array access request
  input logic        acc_allow,  // Array access allowed
  input logic        flash_run,  // Operation running
  input logic [2:0]  flash_op,   // Operation kind
  input logic        id_granted, // Identification matched
  input logic        mode_oe_n,  // Mode pin drive, active low
  input logic        txd_o       // Serial transmit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc    = psel && penable;
  wire mapped = paddr[1:0] == 2'b00 && paddr <= 8'h14;
  wire id_wr  = acc && pwrite && paddr == 8'h14;
  sequence s_bad_setup;
    psel && !penable && !mapped;
  endsequence
  property p_ready_const; pready; endproperty
  property p_slverr; s_bad_setup ##1 acc |-> pslverr; endproperty
  property p_slverr_ok; acc && mapped |-> !pslverr; endproperty
  // Read data and error only move at a setup edge, so the master may sample late.
  property p_stand;
    $past(!(psel && !penable)) |-> $stable(prdata) && $stable(pslverr);
  endproperty
  property p_irq_idle; !flash_run |-> irq_allow; endproperty
  property p_acc_run; flash_run |-> !acc_allow; endproperty
  property p_acc_valid; !acc_valid |-> !acc_allow; endproperty
  property p_run_op; flash_run |-> flash_op != 3'd0; endproperty
  property p_id_rise; $rose(id_granted) |-> $past(id_wr); endproperty
  property p_oe_txd; !mode_oe_n |-> txd_o; endproperty
  a_ready_const: assert property (p_ready_const) else $error("pready low");
  a_slverr: assert property (p_slverr) else $error("no error on unmapped access");
  a_slverr_ok: assert property (p_slverr_ok) else $error("error on mapped access");
  a_stand: assert property (p_stand) else $error("read data moved outside setup");
  a_irq_idle: assert property (p_irq_idle) else $error("irq blocked while idle");
  a_acc_run: assert property (p_acc_run) else $error("access while running");
  a_acc_valid: assert property (p_acc_valid) else $error("allow without request");
  a_run_op: assert property (p_run_op) else $error("running with no kind");
  a_id_rise: assert property (p_id_rise) else $error("grant without id write");
  a_oe_txd: assert property (p_oe_txd) else $error("txd active in mode three");
endmodule
bind flash_seq_ctrl flash_seq_props flash_seq_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_allow(irq_allow), .acc_valid(acc_valid), .acc_allow(acc_allow),
  .flash_run(flash_run), .flash_op(flash_op), .id_granted(id_granted),
  .mode_oe_n(mode_oe_n), .txd_o(txd_o));

//--- tb/flash_macro_model.sv
// Behavioural flash array answering the sequencer's macro controls.
`timescale 1ns/1ps
module flash_macro_model (
  input  wire logic       flash_run,   // Operation running
  input  wire logic [2:0] flash_op,    // Operation kind
  input  wire logic       bad,         // Make results fail
  output logic            op_fail,     // Verify result
  output logic            lock_bit_rd, // Lock bit after programming
  output logic [7:0]      blank_byte,  // Byte seen by blank check
  output logic            blank_valid  // Blank byte strobe
);
  // A failing lock program leaves the bit at 1, which is unlocked.
  assign op_fail     = bad;
  assign lock_bit_rd = bad;
  assign blank_valid = flash_run && flash_op == 3'd5;
  // Outside a strobe the byte is never blank, so a stray sample shows as an error.
  assign blank_byte  = (blank_valid && !bad) ? 8'hFF : 8'h5A;
endmodule

//--- tb/flash_status_and_suspend_control_test.sv
// Self-checking bench for the flash sequencer.
`timescale 1ns/1ps
`include "flash_seq_defs.vh"
module flash_status_and_suspend_control_test;
  logic        pclk, pready, pslverr, op_fail, lock_bit_rd, blank_valid, irq_allow;
  logic        acc_allow, flash_run, id_granted, mode_o, mode_oe_n, txd_o;
  logic        presetn = 0, psel = 0, penable = 0, pwrite = 0, irq_req = 0, irq_ack = 0;
  logic        acc_valid = 0, acc_write = 0, rxd_i = 1, prog_mode = 1, bad = 0;
  logic [7:0]  paddr = 0, acc_block = 0, blank_byte, flash_blk;
  logic [31:0] pwdata = 0, prdata, r;
  logic [2:0]  flash_op;
  logic [7:0]  ops [4] = '{8'h20, 8'h40, 8'h25, 8'h77};
  logic [31:0] errs [4] = '{32'h20, 32'h10, 32'h20, 32'h10};
  int          failures = 0, total_checks = 0, w, i, b;
  logic [55:0] id_code = 56'h12_3456_789A_BCDE;
  wire         mode_pin = mode_oe_n ? prog_mode : mode_o;
  flash_seq_ctrl #(.ERASE_CYC(40), .PROG_CYC(20), .LOCK_CYC(10), .BLANK_CYC(10),
    .SUS_LAT(3)) flash_seq_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_fail(op_fail), .lock_bit_rd(lock_bit_rd), .blank_byte(blank_byte),
    .blank_valid(blank_valid), .irq_req(irq_req), .irq_ack(irq_ack),
    .irq_allow(irq_allow), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_block(acc_block), .acc_allow(acc_allow), .flash_run(flash_run),
    .flash_op(flash_op), .flash_blk(flash_blk), .id_stored(id_code),
    .id_granted(id_granted), .mode_i(mode_pin), .mode_o(mode_o),
    .mode_oe_n(mode_oe_n), .txd_o(txd_o), .rxd_i(rxd_i));
  flash_macro_model flash_macro_model_inst (
    .flash_run(flash_run), .flash_op(flash_op), .bad(bad), .op_fail(op_fail),
    .lock_bit_rd(lock_bit_rd), .blank_byte(blank_byte), .blank_valid(blank_valid));
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0; penable <= 0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] k);
    apb(1, `FS_OFF_CMD, {16'h0, k, c});
  endtask
  task automatic cmd2(input logic [7:0] c, input logic [7:0] d, input logic [7:0] k);
    cmd(c, k);
    cmd(d, k);
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    apb(0, `FS_OFF_STAT, 32'h0);
    chk(r & m, e);
  endtask
  task automatic wrdy;
    w = 0;
    do begin apb(0, `FS_OFF_STAT, 32'h0); w++; end while (r[7] !== 1'b1 && w < 100);
  endtask
  task automatic acc(input logic wr, input logic [7:0] k, input logic e);
    acc_valid <= 1; acc_write <= wr; acc_block <= k;
    @(posedge pclk);
    chk(acc_allow, e);
  endtask
  task automatic do_reset(input logic m);
    presetn <= 0; prog_mode <= m;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic finish_test;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    finish_test;
  end
  initial begin
    do_reset(1);
    apb(0, `FS_OFF_MODE, 32'h0); chk(r, 32'h0);
    apb(0, `FS_OFF_SER, 32'h0); chk(r & 32'h2F, 32'h21);
    apb(0, 8'h40, 32'h0); chk({r[30:0], pslverr}, 32'h1);
    st(32'hB0, 32'h80);
    $display("reset test done");
    cmd(8'h12, 8'h0); st(32'h30, 32'h30);
    cmd(`FS_C_CLRST, 8'h0); st(32'h30, 32'h0);
    cmd2(`FS_C_ERASE, 8'h33, 8'h1); st(32'h30, 32'h30);
    cmd(`FS_C_CLRST, 8'h0);
    cmd2(`FS_C_ERASE, `FS_C_RDARR, 8'h1); st(32'hB0, 32'h80);
    // A lone confirm is only an error if the erase code was really dropped.
    cmd(`FS_C_CONFIRM, 8'h1); st(32'h30, 32'h30);
    cmd(`FS_C_CLRST, 8'h0);
    for (b = 0; b < 2; b++) for (i = 0; i < 4; i++) begin
      bad <= b[0];
      cmd2(ops[i], i == 1 ? 8'hAB : `FS_C_CONFIRM, 8'h1);
      st(32'h80, 32'h0);
      wrdy;
      st(32'h30, b ? errs[i] : 32'h0);
      cmd(`FS_C_CLRST, 8'h0);
    end
    bad <= 0;
    $display("error test done");
    apb(1, `FS_OFF_MODE, 32'h5);
    cmd2(`FS_C_ERASE, `FS_C_CONFIRM, 8'h3);
    @(posedge pclk);
    chk(irq_allow, 32'h1);
    irq_ack <= 1;
    @(posedge pclk);
    irq_ack <= 0;
    repeat (8) @(posedge pclk);
    chk(flash_run, 32'h0);
    st(32'h40, 32'h40);
    apb(0, `FS_OFF_MODE, 32'h0); chk(r & 32'h2, 32'h2);
    acc(1, 8'h3, 0);
    acc(1, 8'h4, 1);
    acc_valid <= 0;
    cmd2(`FS_C_ERASE, `FS_C_CONFIRM, 8'h5); st(32'h30, 32'h30);
    cmd(`FS_C_CLRST, 8'h0);
    cmd2(`FS_C_RDLOCK, `FS_C_CONFIRM, 8'h3); st(32'h30, 32'h30);
    cmd(`FS_C_CLRST, 8'h0);
    apb(1, `FS_OFF_MODE, 32'h5);
    repeat (3) @(posedge pclk);
    chk(flash_run, 32'h1);
    wrdy;
    st(32'h70, 32'h0);
    apb(1, `FS_OFF_MODE, 32'h1);
    cmd2(`FS_C_PROG, 8'h5A, 8'h2);
    apb(1, `FS_OFF_MODE, 32'h3);
    repeat (8) @(posedge pclk);
    st(32'h08, 32'h08);
    cmd2(`FS_C_ERASE, `FS_C_CONFIRM, 8'h5); st(32'h30, 32'h30);
    cmd(`FS_C_CLRST, 8'h0);
    acc(1, 8'h5, 0);
    acc(0, 8'h5, 1);
    acc(0, 8'h2, 0);
    acc_valid <= 0;
    apb(1, `FS_OFF_MODE, 32'h1);
    wrdy;
    st(32'h38, 32'h0);
    $display("mode a test done");
    apb(1, `FS_OFF_MODE, 32'h8);
    cmd2(`FS_C_ERASE, `FS_C_CONFIRM, 8'h3);
    @(posedge pclk);
    chk(irq_allow, 32'h0);
    chk({flash_op, flash_blk}, 32'h103);
    wrdy;
    chk(irq_allow, 32'h1);
    apb(1, `FS_OFF_MODE, 32'hD);
    cmd2(`FS_C_ERASE, `FS_C_CONFIRM, 8'h3);
    irq_req <= 1;
    @(posedge pclk);
    chk(irq_allow, 32'h0);
    repeat (8) @(posedge pclk);
    chk(irq_allow, 32'h1);
    st(32'h40, 32'h40);
    irq_req <= 0;
    apb(1, `FS_OFF_MODE, 32'hD);
    wrdy;
    st(32'h70, 32'h0);
    $display("mode b test done");
    do_reset(0);
    cmd2(`FS_C_PROG, 8'h11, 8'h1); st(32'h81, 32'h80);
    apb(1, `FS_OFF_IDLO, 32'h789A_BCDE);
    apb(1, `FS_OFF_IDHI, 32'h0); st(32'h1, 32'h0);
    apb(1, `FS_OFF_IDHI, 32'h12_3456); st(32'h1, 32'h1);
    chk(id_granted, 32'h1);
    rxd_i <= 0;
    apb(1, `FS_OFF_SER, 32'h0);
    @(posedge pclk);
    chk(txd_o, 32'h0);
    apb(0, `FS_OFF_SER, 32'h0); chk(r & 32'h10, 32'h0);
    rxd_i <= 1;
    // The receive pin needs two edges through its synchroniser before the read.
    repeat (2) @(posedge pclk);
    apb(0, `FS_OFF_SER, 32'h0); chk(r & 32'h10, 32'h10);
    apb(1, `FS_OFF_SER, 32'h6);
    @(posedge pclk);
    chk({mode_oe_n, mode_o, txd_o}, 32'h1);
    rxd_i <= 0;
    prog_mode <= 1;
    apb(1, `FS_OFF_SER, 32'h2);
    repeat (3) @(posedge pclk);
    apb(0, `FS_OFF_SER, 32'h0); chk(r & 32'h10, 32'h10);
    do_reset(1);
    apb(0, `FS_OFF_SER, 32'h0); chk(r & 32'h20, 32'h20);
    cmd2(`FS_C_PROG, 8'h11, 8'h1); st(32'h80, 32'h0);
    $display("serial test done");
    finish_test;
  end
endmodule
